// File: rtl/gpib_msg_pkg.sv
// Package: constants and carrier types for the GP-IB interface message responder
package gpib_msg_pkg;

	// ************************************************************
	// Bus address and command coding
	// ************************************************************
	localparam logic [4:0] ADDR_MAX       = 5'h1e;
	localparam logic [4:0] ADDR_RESET     = 5'h01;
	localparam logic [7:0] CMD_GTL        = 8'h01;
	localparam logic [7:0] CMD_SDC        = 8'h04;
	localparam logic [7:0] CMD_PPC        = 8'h05;
	localparam logic [7:0] CMD_GET        = 8'h08;
	localparam logic [7:0] CMD_TCT        = 8'h09;
	localparam logic [7:0] CMD_LLO        = 8'h11;
	localparam logic [7:0] CMD_DCL        = 8'h14;
	localparam logic [7:0] CMD_PPU        = 8'h15;
	localparam logic [7:0] CMD_SPE        = 8'h18;
	localparam logic [7:0] CMD_SPD        = 8'h19;
	localparam logic [2:0] GRP_LISTEN     = 3'h1;
	localparam logic [2:0] GRP_TALK       = 3'h2;
	localparam logic [4:0] UNADDR_CODE    = 5'h1f;
	localparam int         DATA_POS       = 0;

	// ************************************************************
	// Register map (plain port)
	// ************************************************************
	localparam logic [3:0] REG_CTRL       = 4'h0;
	localparam logic [3:0] REG_STATUS     = 4'h1;
	localparam logic [3:0] REG_STB        = 4'h2;
	localparam logic [3:0] REG_FUNC_V     = 4'h3;
	localparam logic [3:0] REG_FUNC_I     = 4'h4;
	localparam logic [3:0] REG_FUNC_T     = 4'h5;
	localparam logic [3:0] REG_PEND       = 4'h6;
	localparam int         CTRL_ADDR_LSB  = 0;
	localparam int         CTRL_TYPE_BIT  = 5;
	localparam int         CTRL_HIRES_BIT = 6;
	localparam int         CTRL_REN_BIT   = 7;
	localparam logic [31:0] RESET_VALUE   = 32'h0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		TALK_IDLE = 2'b00,
		TALK_DATA = 2'b01,
		TALK_POLL = 2'b11
	} talk_state_t;

	typedef struct packed {
		logic       atn;
		logic       ifc;
		logic       ren;
		logic       dav;
		logic [7:0] dio;
	} bus_in_t;

	typedef struct packed {
		logic       clear_pulse;
		logic       trig_pulse;
		logic       cfg_report_pulse;
		logic       remote;
		logic       lockout;
		logic       listener;
		logic       talker;
		logic       serial_poll;
	} msg_status_t;

	typedef struct packed {
		logic        sign;
		logic [22:0] main;
	} func_setting_t;

endpackage : gpib_msg_pkg

// File: rtl/gpib_pin_sync.sv
// Two-flop synchroniser for the bus control and data lines
`timescale 1ns/100ps
module gpib_pin_sync #(
	parameter int WIDTH = 12
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Lines
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	always_comb begin
		state_next.meta   = async_in;
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stable;

endmodule : gpib_pin_sync

// File: rtl/gpib_panel_setting.sv
// One pending-then-confirmed front-panel setting slot
`timescale 1ns/100ps
module gpib_panel_setting #(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Edit and confirm
	input  wire logic             edit,
	input  wire logic [WIDTH-1:0] edit_value,
	input  wire logic             confirm,
	input  wire logic             clear_pending,
	// Result
	output logic      [WIDTH-1:0] value,
	output logic                  pending
);
	typedef struct packed {
		logic [WIDTH-1:0] committed;
		logic [WIDTH-1:0] staged;
		logic             pending;
	} slot_state_t;

	slot_state_t state_reg;
	slot_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (clear_pending) begin
			state_next.pending = 1'b0;
		end
		if (edit) begin
			state_next.staged  = edit_value;
			state_next.pending = 1'b1;
		end else if (confirm && state_reg.pending) begin
			// Commit only on confirm, then lamps go dark
			state_next.committed = state_reg.staged;
			state_next.pending   = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign value   = state_reg.committed;
	assign pending = state_reg.pending;

endmodule : gpib_panel_setting

// File: rtl/gpib_interface_message_responder.sv
// GP-IB interface message responder: addressing, remote/local, clears, serial poll
// Function
// - Bus address accepted only from zero to thirty
// - Two command types; compatible refused in high-resolution
// - Command type change applies after power cycle
// - Compatible type rejects standard commands, disables USB/LAN
// - IFC unaddresses talker/listener, stops transmission
// - REN line switches remote and local
// - IDY, PPC, TCT, PPU ignored
// - Addressed GTL returns to local mode
// - SDC clears input, output queue, pending waits
// - GET in compatible type reports configuration status
// - Lockout blocks front-panel return to local
// - DCL clears like SDC, addressed or not
// - SPE sets poll mode; talker returns status
// - SPD leaves poll mode, normal output resumes
// - GTL/SDC/GET need listen address; universals always
// - Multi-line from data lines, uni-line dedicated
// - Separate polarity and setting per function
// - Panel change pending until confirm, then commits
// - Remote disables panel except output-local switch
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module gpib_interface_message_responder
	import gpib_msg_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	// Bus lines (asynchronous)
	input  wire gpib_msg_pkg::bus_in_t       bus_in,
	// Bus talker output byte
	output logic      [7:0]                  talk_data,
	output logic                             talk_valid,
	// Host data side
	input  wire logic [7:0]                  out_data,
	input  wire logic                        out_valid,
	input  wire logic                        out_busy,
	// Front panel
	input  wire logic                        panel_local_req,
	input  wire logic                        panel_edit,
	input  wire logic [1:0]                  panel_func_sel,
	input  wire logic [23:0]                 panel_value,
	input  wire logic                        panel_confirm,
	output logic                             panel_enable,
	output logic                             panel_pending,
	// Register port
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata,
	// Status to the message processor
	output gpib_msg_pkg::msg_status_t        msg_status,
	output logic                             std_cmd_enable,
	output logic                             usb_lan_enable,
	output logic                             compat_refused
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [4:0]  addr;
		logic        type_active;
		logic        type_loaded;
		logic        hires;
		logic [7:0]  stb;
		logic        listener;
		logic        talker;
		talk_state_t talk;
		logic        remote;
		logic        lockout;
		logic        dav_prev;
		logic        clear_pulse;
		logic        trig_pulse;
		logic        report_pulse;
		logic [7:0]  tx_data;
		logic        tx_valid;
		logic [31:0] rdata;
	} resp_state_t;

	resp_state_t state_reg;
	resp_state_t state_next;
	bus_in_t     bus_sync;
	logic [2:0]  pend_vec;
	logic [23:0] func_val [3];
	// Stands for the nonvolatile type store: powers up standard, reset leaves it alone
	logic        type_nv_reg = 1'b0;

	function automatic logic is_addressed_cmd(input logic [7:0] c);
		is_addressed_cmd = (c == CMD_GTL) || (c == CMD_SDC) || (c == CMD_GET);
	endfunction : is_addressed_cmd

	gpib_pin_sync #(
		.WIDTH($bits(bus_in_t))
	) u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.async_in (bus_in),
		.sync_out (bus_sync)
	);

	// ************************************************************
	// Per-function settings
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_func
			gpib_panel_setting #(
				.WIDTH(24)
			) u_slot (
				.clk_sys       (clk_sys),
				.rstn          (rstn),
				.edit          (panel_edit && panel_enable && panel_func_sel == 2'(gi)),
				.edit_value    (panel_value),
				.confirm       (panel_confirm && panel_enable),
				.clear_pending (state_reg.remote),
				.value         (func_val[gi]),
				.pending       (pend_vec[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Message decode
	// ************************************************************
	logic       byte_strobe;
	logic [7:0] cmd;
	logic       is_cmd;
	logic       my_listen;
	logic       my_talk;

	always_comb begin
		byte_strobe = bus_sync.dav && !state_reg.dav_prev;
		cmd         = bus_sync.dio & 8'h7f;
		is_cmd      = byte_strobe && bus_sync.atn;
		my_listen   = is_cmd && cmd[7:5] == GRP_LISTEN && cmd[4:0] == state_reg.addr;
		my_talk     = is_cmd && cmd[7:5] == GRP_TALK && cmd[4:0] == state_reg.addr;
	end

	always_comb begin
		state_next              = state_reg;
		state_next.dav_prev     = bus_sync.dav;
		state_next.clear_pulse  = 1'b0;
		state_next.trig_pulse   = 1'b0;
		state_next.report_pulse = 1'b0;
		state_next.rdata        = '0;
		// Type latches once after reset, which stands for power-on
		if (!state_reg.type_loaded) begin
			state_next.type_active = type_nv_reg;
			state_next.type_loaded = 1'b1;
		end
		// Addressing
		if (is_cmd && cmd[7:5] == GRP_LISTEN) begin
			if (cmd[4:0] == UNADDR_CODE) begin
				state_next.listener = 1'b0;
			end else if (my_listen) begin
				state_next.listener = 1'b1;
				state_next.talker   = 1'b0;
			end
		end
		if (is_cmd && cmd[7:5] == GRP_TALK) begin
			if (my_talk) begin
				state_next.talker   = 1'b1;
				state_next.listener = 1'b0;
			end else begin
				state_next.talker = 1'b0;
			end
		end
		// Addressed commands need listen; universals always
		if (is_cmd && is_addressed_cmd(cmd) && state_reg.listener) begin
			case (cmd)
				CMD_GTL: begin
					state_next.remote = 1'b0;
				end
				CMD_SDC: begin
					state_next.clear_pulse = 1'b1;
					state_next.tx_valid    = 1'b0;
				end
				CMD_GET: begin
					state_next.trig_pulse   = 1'b1;
					state_next.report_pulse = state_reg.type_active;
				end
				default: begin
				end
			endcase
		end
		// PPC, TCT, PPU and IDY fall through with no effect
		if (is_cmd) begin
			case (cmd)
				CMD_LLO: begin
					state_next.lockout = 1'b1;
				end
				CMD_DCL: begin
					state_next.clear_pulse = 1'b1;
					state_next.tx_valid    = 1'b0;
				end
				CMD_SPE: begin
					state_next.talk = TALK_POLL;
				end
				CMD_SPD: begin
					state_next.talk = TALK_DATA;
				end
				default: begin
				end
			endcase
		end
		// Talker output
		if (state_reg.talker && !bus_sync.atn) begin
			if (state_reg.talk == TALK_POLL) begin
				state_next.tx_data  = state_reg.stb;
				state_next.tx_valid = 1'b1;
			end else if (out_valid && !out_busy) begin
				state_next.tx_data  = out_data;
				state_next.tx_valid = 1'b1;
			end
		end else if (!state_reg.talker) begin
			state_next.tx_valid = 1'b0;
		end
		// Remote and local from the REN line
		if (!bus_sync.ren) begin
			state_next.remote  = 1'b0;
			state_next.lockout = 1'b0;
		end else if (state_reg.listener && !state_reg.remote && my_listen) begin
			state_next.remote = 1'b1;
		end else if (!state_reg.remote && is_cmd && my_listen) begin
			state_next.remote = 1'b1;
		end
		if (state_reg.remote && panel_local_req && !state_reg.lockout) begin
			state_next.remote = 1'b0;
		end
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: begin
					if (reg_wdata[CTRL_ADDR_LSB +: 5] <= ADDR_MAX) begin
						state_next.addr = reg_wdata[CTRL_ADDR_LSB +: 5];
					end
					state_next.hires = reg_wdata[CTRL_HIRES_BIT];
				end
				REG_STB: begin
					state_next.stb = reg_wdata[7:0];
				end
				default: begin
				end
			endcase
		end
		// Register reads
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: begin
					state_next.rdata = {24'h0, 1'b0, state_reg.hires, type_nv_reg,
						state_reg.addr};
				end
				REG_STATUS: begin
					state_next.rdata = {24'h0, state_reg.type_active, state_reg.lockout,
						state_reg.remote, state_reg.talk, state_reg.talker,
						state_reg.listener, state_reg.tx_valid};
				end
				REG_STB: begin
					state_next.rdata = {24'h0, state_reg.stb};
				end
				REG_FUNC_V: begin
					state_next.rdata = {8'h0, func_val[0]};
				end
				REG_FUNC_I: begin
					state_next.rdata = {8'h0, func_val[1]};
				end
				REG_FUNC_T: begin
					state_next.rdata = {8'h0, func_val[2]};
				end
				REG_PEND: begin
					state_next.rdata = {29'h0, pend_vec};
				end
				default: begin
					state_next.rdata = RESET_VALUE;
				end
			endcase
		end
		// IFC overrides everything on the talk/listen side
		if (bus_sync.ifc) begin
			state_next.listener = 1'b0;
			state_next.talker   = 1'b0;
			state_next.tx_valid = 1'b0;
			state_next.talk     = TALK_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg      <= '0;
			state_reg.addr <= ADDR_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// No reset here, else the stored type could never outlive a power cycle
	always_ff @(posedge clk_sys) begin
		if (reg_wr && reg_addr == REG_CTRL) begin
			type_nv_reg <= reg_wdata[CTRL_TYPE_BIT];
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign talk_data                   = state_reg.tx_data;
	assign talk_valid                  = state_reg.tx_valid;
	assign reg_rdata                   = state_reg.rdata;
	assign panel_enable                = !state_reg.remote;
	assign panel_pending               = |pend_vec;
	assign std_cmd_enable              = !state_reg.type_active;
	assign usb_lan_enable              = !state_reg.type_active;
	assign compat_refused              = state_reg.type_active && state_reg.hires;
	assign msg_status.clear_pulse      = state_reg.clear_pulse;
	assign msg_status.trig_pulse       = state_reg.trig_pulse;
	assign msg_status.cfg_report_pulse = state_reg.report_pulse;
	assign msg_status.remote           = state_reg.remote;
	assign msg_status.lockout          = state_reg.lockout;
	assign msg_status.listener         = state_reg.listener;
	assign msg_status.talker           = state_reg.talker;
	assign msg_status.serial_poll      = state_reg.talk == TALK_POLL;

	// ************************************************************
	// Checks
	// ************************************************************
	ifc_clears_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		bus_sync.ifc |=> !state_reg.listener && !state_reg.talker && !talk_valid)
		else $error("IFC did not clear talker and listener");
	ren_low_local_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!bus_sync.ren |=> !state_reg.remote)
		else $error("Remote held with REN low");
	dcl_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_cmd && cmd == CMD_DCL |=> msg_status.clear_pulse)
		else $error("DCL gave no clear");
	sdc_unaddr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_cmd && cmd == CMD_SDC && !state_reg.listener |=> !msg_status.clear_pulse)
		else $error("SDC acted while unaddressed");
	spe_poll_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_cmd && cmd == CMD_SPE && !bus_sync.ifc |=> msg_status.serial_poll)
		else $error("SPE did not enter poll mode");
	spd_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_cmd && cmd == CMD_SPD |=> !msg_status.serial_poll)
		else $error("SPD left poll mode set");
	addr_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.addr <= ADDR_MAX)
		else $error("Bus address above thirty");
	type_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.type_loaded |=> $stable(state_reg.type_active))
		else $error("Command type changed without power cycle");
	lockout_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.remote && state_reg.lockout && bus_sync.ren && panel_local_req
		&& !(is_cmd && cmd == CMD_GTL) |=> state_reg.remote)
		else $error("Panel left remote under lockout");
	get_report_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		msg_status.cfg_report_pulse |-> state_reg.type_active && $past(state_reg.listener))
		else $error("GET report without compatible type");

endmodule : gpib_interface_message_responder

// File: tb/gpib_ctrl_model.sv
// Controller model: sources command bytes on the device's bus lines
`timescale 1ns/100ps
module gpib_ctrl_model (
	// Clock
	input  wire logic             clk_sys,
	// Bench requests
	input  wire logic             atn_lvl,
	input  wire logic             ifc_lvl,
	input  wire logic             ren_lvl,
	input  wire logic             go,
	input  wire logic [7:0]       cmd_byte,
	output logic                  done,
	// Bus lines
	output gpib_msg_pkg::bus_in_t bus_out
);
	import gpib_msg_pkg::*;

	logic [3:0] phase_reg = 4'h0;
	logic [7:0] byte_reg  = 8'h00;
	logic       dav_w;
	logic [7:0] dio_w;

	initial done = 1'b0;

	// Interface bytes only, never an output change, so no settle wait is owed
	// Sole interface in use; one byte per request, dav high five clocks, then low three clocks before done
	always @(posedge clk_sys) begin
		done <= 1'b0;
		if (phase_reg == 4'h0) begin
			if (go) begin
				byte_reg  <= cmd_byte;
				phase_reg <= 4'h1;
			end
		end else if (phase_reg == 4'h9) begin
			phase_reg <= 4'h0;
			done      <= 1'b1;
		end else begin
			phase_reg <= phase_reg + 4'h1;
		end
	end

	// Data settles a clock before dav; idle lines show the inverse, not a stale copy
	assign dav_w   = (phase_reg >= 4'h2) && (phase_reg <= 4'h6);
	assign dio_w   = (phase_reg >= 4'h1 && phase_reg <= 4'h7) ? byte_reg : ~byte_reg;
	assign bus_out = '{atn: atn_lvl, ifc: ifc_lvl, ren: ren_lvl, dav: dav_w, dio: dio_w};
endmodule : gpib_ctrl_model

// File: tb/tb_gpib_interface_message_responder.sv
// Self-checking testbench for the GP-IB interface message responder
`timescale 1ns/100ps
module tb_gpib_interface_message_responder;
	import gpib_msg_pkg::*;

	// ************************************************************
	// Clock, reset and design
	// ************************************************************
	logic        clk_sys;
	logic        rstn;
	logic        atn_lvl;
	logic        ifc_lvl;
	logic        ren_lvl;
	logic        go;
	logic        done;
	logic [7:0]  cmd_byte;
	bus_in_t     bus;
	logic [7:0]  talk_data;
	logic        talk_valid;
	logic        out_valid;
	logic        panel_local_req;
	logic        panel_edit;
	logic [1:0]  panel_func_sel;
	logic [23:0] panel_value;
	logic        panel_confirm;
	logic        panel_enable;
	logic        panel_pending;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	msg_status_t msg_status;
	logic        std_cmd_enable;
	logic        usb_lan_enable;
	logic        compat_refused;
	logic [31:0] rv;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          clr_n      = 0;
	int          trg_n      = 0;
	int          cfg_n      = 0;

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	gpib_ctrl_model ctrl_u (.clk_sys(clk_sys), .atn_lvl(atn_lvl), .ifc_lvl(ifc_lvl),
		.ren_lvl(ren_lvl), .go(go), .cmd_byte(cmd_byte), .done(done), .bus_out(bus));

	gpib_interface_message_responder dut_u (.clk_sys(clk_sys), .rstn(rstn), .bus_in(bus),
		.talk_data(talk_data), .talk_valid(talk_valid), .out_data(8'h5a),
		.out_valid(out_valid), .out_busy(1'b0), .panel_local_req(panel_local_req),
		.panel_edit(panel_edit), .panel_func_sel(panel_func_sel),
		.panel_value(panel_value), .panel_confirm(panel_confirm),
		.panel_enable(panel_enable), .panel_pending(panel_pending),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .msg_status(msg_status), .std_cmd_enable(std_cmd_enable),
		.usb_lan_enable(usb_lan_enable), .compat_refused(compat_refused));

	// Pulses last one cycle, so they are counted rather than sampled
	always @(negedge clk_sys) begin
		if (msg_status.clear_pulse === 1'b1) clr_n++;
		if (msg_status.trig_pulse === 1'b1) trg_n++;
		if (msg_status.cfg_report_pulse === 1'b1) cfg_n++;
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : idle

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		cmd_byte <= b;
		go       <= 1'b1;
		@(posedge clk_sys);
		go       <= 1'b0;
		for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk_sys);
		idle(2);
	endtask : send

	task automatic stage(input logic [1:0] sel, input logic [23:0] val, input logic commit);
		@(posedge clk_sys);
		panel_func_sel <= sel;
		panel_value    <= val;
		panel_edit     <= ~commit;
		panel_confirm  <= commit;
		@(posedge clk_sys);
		panel_edit     <= 1'b0;
		panel_confirm  <= 1'b0;
		idle(4);
	endtask : stage

	task automatic local_req();
		@(posedge clk_sys);
		panel_local_req <= 1'b1;
		repeat (5) @(posedge clk_sys);
		panel_local_req <= 1'b0;
		idle(4);
	endtask : local_req

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		chk({panel_enable, std_cmd_enable, usb_lan_enable, compat_refused}, 4'he);
		rd(REG_CTRL, rv);
		chk(rv, 32'h1);
		wr(REG_CTRL, 32'h1f);
		rd(REG_CTRL, rv);
		chk(rv, 32'h1);
		wr(REG_CTRL, 32'h1e);
		rd(REG_CTRL, rv);
		chk(rv, 32'h1e);
		wr(REG_CTRL, 32'h25);
		idle(3);
		chk({std_cmd_enable, usb_lan_enable}, 2'h3);
		rd(REG_STATUS, rv);
		chk(rv[7], 1'b0);
		wr(REG_CTRL, 32'h05);                                 // Bus idle while it moves
		rd(4'hf, rv);
		chk(rv, 32'h0);
	endtask : t_regs

	task automatic t_panel();
		stage(2'h0, 24'h123456, 1'b0);
		chk(panel_pending, 1'b1);
		rd(REG_FUNC_V, rv);
		chk(rv, 32'h0);
		stage(2'h0, 24'h123456, 1'b1);
		chk(panel_pending, 1'b0);
		stage(2'h2, 24'h7fffff, 1'b0);
		stage(2'h2, 24'h7fffff, 1'b1);
		rd(REG_FUNC_V, rv);
		chk(rv, 32'h123456);
		rd(REG_FUNC_I, rv);
		chk(rv, 32'h0);
		rd(REG_FUNC_T, rv);
		chk(rv, 32'h7fffff);
	endtask : t_panel

	task automatic t_remote();
		@(posedge clk_sys);
		ren_lvl <= 1'b1;
		send(8'h25);
		chk({msg_status.listener, msg_status.remote, panel_enable}, 3'h6);
		local_req();
		chk({msg_status.remote, panel_enable}, 2'h1);
		send(8'h25);
		send(CMD_GTL);
		chk(msg_status.remote, 1'b0);
		send(8'h25);
		send(CMD_LLO);
		local_req();
		chk({msg_status.remote, msg_status.lockout}, 2'h3);
		@(posedge clk_sys);
		ren_lvl <= 1'b0;
		idle(6);
		chk({msg_status.remote, msg_status.lockout}, 2'h0);
	endtask : t_remote

	task automatic t_clear();
		int          ec;
		int          et;
		logic [7:0]  ign [3];
		ign = '{CMD_PPC, CMD_TCT, CMD_PPU};
		ec  = clr_n;
		et  = trg_n;
		send(8'h25);
		send(CMD_SDC);
		send(CMD_GET);
		chk(clr_n, ec + 1);
		chk(trg_n, et + 1);
		chk(cfg_n, 0);
		foreach (ign[i]) send(ign[i]);
		chk({16'(clr_n), 16'(trg_n)}, {16'(ec + 1), 16'(et + 1)});
		chk(msg_status.listener, 1'b1);
		send(8'h3f);
		send(CMD_SDC);
		send(CMD_GET);
		send(CMD_GTL);
		chk({16'(clr_n), 16'(trg_n)}, {16'(ec + 1), 16'(et + 1)});
		send(CMD_DCL);
		chk(clr_n, ec + 2);
	endtask : t_clear

	task automatic t_poll();
		wr(REG_STB, 32'h42);
		send(CMD_SPE);
		send(8'h45);
		@(posedge clk_sys);
		atn_lvl <= 1'b0;
		idle(6);
		chk({msg_status.talker, msg_status.serial_poll, talk_valid}, 3'h7);
		chk(talk_data, 8'h42);
		@(posedge clk_sys);
		atn_lvl <= 1'b1;
		send(CMD_SPD);
		chk(msg_status.serial_poll, 1'b0);
		@(posedge clk_sys);
		atn_lvl   <= 1'b0;
		out_valid <= 1'b1;
		idle(6);
		chk(talk_data, 8'h5a);
		@(posedge clk_sys);
		atn_lvl   <= 1'b1;
		out_valid <= 1'b0;
		@(posedge clk_sys);
		ifc_lvl <= 1'b1;
		idle(4);
		@(posedge clk_sys);
		ifc_lvl <= 1'b0;
		idle(4);
		chk({msg_status.listener, msg_status.talker, talk_valid}, 3'h0);
	endtask : t_poll

	// Stored compatible type only takes hold across a reset, which stands for power-on
	task automatic t_compat();
		wr(REG_CTRL, 32'h65);
		idle(2);
		chk({std_cmd_enable, usb_lan_enable, compat_refused}, 3'h6);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		idle(3);
		chk({std_cmd_enable, usb_lan_enable}, 2'h0);
		chk(compat_refused, 1'b0);
		wr(REG_CTRL, 32'h41);
		idle(2);
		chk(compat_refused, 1'b1);
		rd(REG_STATUS, rv);
		chk(rv[7], 1'b1);
		send(8'h21);
		send(CMD_GET);
		chk(cfg_n, 1);
	endtask : t_compat

	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Whole sequence needs under a thousand cycles; this allows over thirty times that
	initial begin
		#300000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		rstn            = 1'b0;
		atn_lvl         = 1'b1;
		ifc_lvl         = 1'b0;
		ren_lvl         = 1'b0;
		go              = 1'b0;
		cmd_byte        = 8'h00;
		out_valid       = 1'b0;
		panel_local_req = 1'b0;
		panel_edit      = 1'b0;
		panel_func_sel  = 2'h0;
		panel_value     = 24'h000000;
		panel_confirm   = 1'b0;
		reg_addr        = 4'h0;
		reg_wdata       = 32'h0;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		idle(2);
		t_regs();
		t_panel();
		t_remote();
		t_clear();
		t_poll();
		t_compat();
		tally_and_finish();
	end
endmodule : tb_gpib_interface_message_responder
